/* File: hw/lsr_pkg.sv */
package lsr_pkg;

  localparam int SIG_BYTES = 22;
  localparam int IDX_W     = 5;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OSC_2M_TRIM  = 5'h00;
  localparam logic [IDX_W-1:0] IDX_OSC_32K_TRIM = 5'h02;
  localparam logic [IDX_W-1:0] IDX_OSC_32M_TRIM = 5'h03;
  localparam logic [IDX_W-1:0] IDX_LOT_BYTE_0   = 5'h08;
  localparam logic [IDX_W-1:0] IDX_LOT_BYTE_1   = 5'h09;
  localparam logic [IDX_W-1:0] IDX_LOT_BYTE_2   = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_LOT_BYTE_3   = 5'h0B;
  localparam logic [IDX_W-1:0] IDX_LOT_BYTE_4   = 5'h0C;
  localparam logic [IDX_W-1:0] IDX_LOT_BYTE_5   = 5'h0D;
  localparam logic [IDX_W-1:0] IDX_WAFER_INDEX  = 5'h10;
  localparam logic [IDX_W-1:0] IDX_WAFER_X_LOW  = 5'h12;
  localparam logic [IDX_W-1:0] IDX_WAFER_X_HIGH = 5'h13;
  localparam logic [IDX_W-1:0] IDX_WAFER_Y_LOW  = 5'h14;
  localparam logic [IDX_W-1:0] IDX_WAFER_Y_HIGH = 5'h15;
  localparam logic [IDX_W-1:0] IDX_PROT_STATUS  = 5'h18;
  localparam logic [IDX_W-1:0] IDX_CTRL         = 5'h19;

  localparam int ADDR_LSB = 2;

  // Control register fields
  localparam int CTRL_RELOAD_BIT = 0;

  // Status register fields
  localparam int STAT_PROT_LSB   = 0;
  localparam int STAT_TEST_BIT   = 2;
  localparam int STAT_DEBUG_BIT  = 3;

  // Protection level encodings
  localparam logic [1:0] PROT_UNLOCKED           = 2'h3;
  localparam logic [1:0] PROT_WRITE_BLOCKED      = 2'h2;
  localparam logic [1:0] PROT_READ_WRITE_BLOCKED = 2'h0;
  localparam logic [1:0] PROT_RESET_VALUE        = PROT_UNLOCKED;

  typedef enum logic [2:0] {
    CMD_FLASH_WRITE = 3'h0,
    CMD_FLASH_READ  = 3'h1,
    CMD_FUSE_WRITE  = 3'h2,
    CMD_FUSE_READ   = 3'h3,
    CMD_PROT_WRITE  = 3'h4,
    CMD_PROT_READ   = 3'h5,
    CMD_CHIP_ERASE  = 3'h6
  } lsr_cmd_t;

  typedef struct packed {
    logic [2:0] cmd;
    logic [7:0] data;
  } lsr_prog_req_t;

  typedef struct packed {
    logic mem_wr;
    logic mem_rd;
    logic fuse_wr;
    logic fuse_rd;
    logic prot_wr;
    logic prot_rd;
    logic erase;
  } lsr_grant_t;

  typedef struct packed {
    logic [7:0] fll_2m_trim_reg_b;
    logic [7:0] low_freq_osc_trim_reg;
    logic [7:0] fll_32m_trim_reg_b;
  } lsr_trim_t;

endpackage

/* File: hw/lsr_prog_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module lsr_prog_gate
  import lsr_pkg::*;
(
  input  wire logic [1:0] prot_level,
  input  wire logic [2:0] cmd,
  output lsr_grant_t      grant
);

  // Bit 1 low means full lock (00, and 01 taken as 00); otherwise bit 0 low means write lock
  function automatic lsr_grant_t decide(input logic [1:0] lvl, input logic [2:0] c);
    logic       rw_lock;
    logic       w_lock;
    lsr_grant_t g;
    rw_lock = ~lvl[1];                                        // R8 R9
    w_lock  = ~lvl[0] | rw_lock;                              // R6 R7
    g       = '0;
    unique case (c)
      CMD_FLASH_WRITE: g.mem_wr  = ~w_lock;                   // R5 R6
      CMD_FLASH_READ:  g.mem_rd  = ~rw_lock;                  // R8
      CMD_FUSE_WRITE:  g.fuse_wr = ~w_lock;                   // R7
      CMD_FUSE_READ:   g.fuse_rd = ~rw_lock;                  // R9
      CMD_PROT_WRITE:  g.prot_wr = ~rw_lock;                  // R9
      CMD_PROT_READ:   g.prot_rd = ~rw_lock;                  // R9
      CMD_CHIP_ERASE:  g.erase   = 1'b1;                      // R2
      default:         g         = '0;
    endcase
    return g;
  endfunction

  assign grant = decide(prot_level, cmd);

endmodule
`default_nettype wire

/* File: hw/lsr_sig_rom.sv */
`timescale 1ns/100ps
`default_nettype none
module lsr_sig_rom
  import lsr_pkg::*;
#(
  parameter logic [8*SIG_BYTES-1:0] ROW = '0
)
(
  input  wire logic [IDX_W-1:0] idx,
  output logic      [7:0]       data,
  output logic                  hit
);

  // Factory row is fixed at build time, so no path can change it
  logic [7:0] row_mem [SIG_BYTES];

  genvar gi;
  generate
    for (gi = 0; gi < SIG_BYTES; gi++)
    begin : g_row
      assign row_mem[gi] = ROW[8*gi +: 8];                    // R17
    end
  endgenerate

  always_comb
  begin
    unique case (idx)
      IDX_OSC_2M_TRIM, IDX_OSC_32K_TRIM, IDX_OSC_32M_TRIM,
      IDX_LOT_BYTE_0, IDX_LOT_BYTE_1, IDX_LOT_BYTE_2,
      IDX_LOT_BYTE_3, IDX_LOT_BYTE_4, IDX_LOT_BYTE_5,
      IDX_WAFER_INDEX,
      IDX_WAFER_X_LOW, IDX_WAFER_X_HIGH,
      IDX_WAFER_Y_LOW, IDX_WAFER_Y_HIGH:
      begin
        hit  = 1'b1;                                          // R14 R15 R16
        data = row_mem[idx];
      end
      default:
      begin
        hit  = 1'b0;
        data = 8'h00;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: hw/lsr_top.sv */
// Overview of operation
// [R1] The protection level field is written only by the programming interface; bus writes to it are ignored.
// [R2] The field returns to unlocked only through chip erase; ordinary writes can only clear bits. Here an nv_rst_n reset also loads unlocked.
// [R3] Any zero bit in the field shuts the test access path and the on-chip debug path.
// [R4] The field never gates memory accesses made by on-chip software.
// [R5] At level 11 the programming interface has no restriction.
// [R6] At level 10 flash and EEPROM programming over the programming interface is refused.
// [R7] At level 10 fuse writes over the programming interface are refused.
// [R8] At level 00 flash and EEPROM programming and read or verify over the programming interface are refused.
// [R9] At level 00 fuses and the protection field can be neither read nor written over the programming interface.
// [R10] The programmer sets fuses and boot section protection before the protection field.
// [R11] In reset the signature byte at 0x00 goes into trim register B of the 2MHz loop.
// [R12] In reset the signature byte at 0x02 goes into the low-frequency oscillator trim register.
// [R13] In reset the signature byte at 0x03 goes into trim register B of the 32MHz loop.
// [R14] Lot identifier bytes 0 to 5 sit read-only at offsets 0x08 to 0x0D.
// [R15] Wafer X and Y sit read-only as low and high bytes, X at 0x12 and 0x13, Y at 0x14 and 0x15.
// [R16] A read-only wafer number byte completes the serial identifier.
// [R17] Signature bytes ignore writes and always read their factory value.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module lsr_top
  import lsr_pkg::*;
#(
  parameter int                     ADDR_W = 12,
  parameter logic [8*SIG_BYTES-1:0] ROW    = {SIG_BYTES{8'h5A}}
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              nv_rst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  input  wire logic              prog_valid,
  input  wire lsr_prog_req_t     prog_req,
  output logic                   prog_done,
  output logic                   prog_denied,
  output logic      [7:0]        prog_rdata,
  output lsr_grant_t             prog_grant,
  output logic                   test_access_en,
  output logic                   debug_access_en,
  output lsr_trim_t              trim,
  output logic                   trim_loaded
);

  ////////////////////////////////////////////////////////////////////////////
  // Signature row and programming gate

  logic [IDX_W-1:0] bus_idx;
  logic [7:0]       row_byte;
  logic             row_hit;
  logic [1:0]       prot_level_r;
  lsr_grant_t       gate_grant;

  assign bus_idx = paddr[ADDR_LSB +: IDX_W];

  lsr_sig_rom #(
    .ROW (ROW)
  ) u_rom (
    .idx  (bus_idx),
    .data (row_byte),
    .hit  (row_hit)
  );

  lsr_prog_gate u_gate (
    .prot_level (prot_level_r),
    .cmd        (prog_req.cmd),
    .grant      (gate_grant)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protection level field

  // Held on its own reset so a system reset does not unlock the part
  logic [1:0] prot_level_nxt;

  always_comb
  begin
    prot_level_nxt = prot_level_r;
    if (prog_valid && gate_grant.erase)
    begin
      prot_level_nxt = PROT_UNLOCKED;                         // R2
    end
    else if (prog_valid && gate_grant.prot_wr)
    begin
      // Only clearing allowed, so a write can never raise the level
      prot_level_nxt = prot_level_r & prog_req.data[1:0];     // R1 R2
    end
  end

  always_ff @(posedge pclk or negedge nv_rst_n)
  begin
    if (!nv_rst_n)
    begin
      prot_level_r <= PROT_RESET_VALUE;
    end
    else if (ce)
    begin
      prot_level_r <= prot_level_nxt;
    end
  end

  // Both bits must be set for external debug or test entry
  assign test_access_en  = &prot_level_r;                     // R3
  assign debug_access_en = &prot_level_r;                     // R3

  ////////////////////////////////////////////////////////////////////////////
  // Programming interface answer

  lsr_grant_t g_masked;

  assign g_masked = prog_valid ? gate_grant : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_done   <= 1'b0;
      prog_denied <= 1'b0;
      prog_grant  <= '0;
    end
    else if (ce)
    begin
      prog_done   <= prog_valid;
      prog_denied <= prog_valid && (g_masked == '0);          // R6 R7 R8 R9
      prog_grant  <= g_masked;                                // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_rdata <= 8'h00;
    end
    else if (ce && prog_valid)
    begin
      // Refused reads show zero so nothing of the field leaks out
      prog_rdata <= g_masked.prot_rd ? {6'h00, prot_level_r} : 8'h00; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator trim loading

  logic reload_req;

  // Factory row is a constant, so the async reset itself loads the trims
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim.fll_2m_trim_reg_b     <= ROW[8*IDX_OSC_2M_TRIM +: 8];  // R11
      trim.low_freq_osc_trim_reg <= ROW[8*IDX_OSC_32K_TRIM +: 8]; // R12
      trim.fll_32m_trim_reg_b    <= ROW[8*IDX_OSC_32M_TRIM +: 8]; // R13
    end
    else if (ce && reload_req)
    begin
      trim.fll_2m_trim_reg_b     <= ROW[8*IDX_OSC_2M_TRIM +: 8];  // R11
      trim.low_freq_osc_trim_reg <= ROW[8*IDX_OSC_32K_TRIM +: 8]; // R12
      trim.fll_32m_trim_reg_b    <= ROW[8*IDX_OSC_32M_TRIM +: 8]; // R13
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_loaded <= 1'b1;
    end
    else if (ce)
    begin
      trim_loaded <= reload_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic setup_ph;
  logic addr_ok;
  logic is_ctrl;
  logic is_stat;
  logic [7:0] rd_byte;
  logic rd_ok;

  assign setup_ph = psel && !penable;
  assign addr_ok  = (paddr[ADDR_W-1:ADDR_LSB+IDX_W] == '0) && (paddr[ADDR_LSB-1:0] == '0);
  assign is_ctrl  = addr_ok && (bus_idx == IDX_CTRL);
  assign is_stat  = addr_ok && (bus_idx == IDX_PROT_STATUS);

  // One wait-free access phase; read data was caught in setup
  assign pready = 1'b1;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok   = 1'b0;
    if (addr_ok && row_hit)
    begin
      rd_byte = row_byte;                                     // R14 R15 R16 R17
      rd_ok   = 1'b1;
    end
    else if (is_stat)
    begin
      rd_byte[STAT_PROT_LSB +: 2] = prot_level_r;
      rd_byte[STAT_TEST_BIT]      = test_access_en;
      rd_byte[STAT_DEBUG_BIT]     = debug_access_en;
      rd_ok   = 1'b1;
    end
    else if (is_ctrl)
    begin
      rd_ok   = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (ce && setup_ph)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      // Writes only land on the control word; all else is refused
      pslverr <= pwrite ? !is_ctrl : !rd_ok;                  // R1 R17
    end
  end

  // Reload strobe is registered at the access edge and loads the trims one edge later; bus never reaches the lock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reload_req <= 1'b0;
    end
    else if (ce)
    begin
      reload_req <= psel && penable && pwrite && is_ctrl && pwdata[CTRL_RELOAD_BIT];
    end
  end

  // On-chip software memory paths bypass this block entirely        R4

endmodule
`default_nettype wire

/* File: tb/lsr_top_props.sv */
`timescale 1ns/100ps
`default_nettype none
module lsr_top_props
  import lsr_pkg::*;
#(
  parameter logic [8*SIG_BYTES-1:0] ROW = '0
)
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          ce,
  input wire logic          prog_valid,
  input wire lsr_prog_req_t prog_req,
  input wire logic          prog_done,
  input wire logic          prog_denied,
  input wire logic [7:0]    prog_rdata,
  input wire lsr_grant_t    prog_grant,
  input wire logic          test_access_en,
  input wire logic          debug_access_en,
  input wire lsr_trim_t     trim
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_req;
    prog_valid && ce;
  endsequence
  // Only a write that leaves a zero bit from the open level
  sequence s_lock;
    s_req ##0 prog_req.cmd == CMD_PROT_WRITE && prog_req.data[1:0] != 2'h3 && test_access_en;
  endsequence
  AST_ANSWER: assert property (s_req |=> prog_done)
    else $error("no answer");
  AST_LOCK_SHUTS: assert property (s_lock |=> !test_access_en && !debug_access_en)
    else $error("paths open");
  AST_ERASE_ONLY: assert property ($rose(test_access_en) |-> $past(prog_valid && ce && prog_req.cmd == CMD_CHIP_ERASE))
    else $error("unlock without erase");
  AST_MEM_WR: assert property (prog_grant.mem_wr |-> $past(test_access_en))
    else $error("mem write granted");
  AST_FUSE_WR: assert property (prog_grant.fuse_wr |-> $past(test_access_en))
    else $error("fuse write granted");
  AST_PROT_RD: assert property (prog_grant.prot_rd |-> prog_rdata inside {8'h02, 8'h03})
    else $error("level read wrong");
  AST_DENY: assert property (prog_denied |-> prog_done && prog_grant == '0)
    else $error("denied with grant");
  AST_TRIM_2M: assert property (trim.fll_2m_trim_reg_b == ROW[7:0])
    else $error("trim 2m");
  AST_TRIM_32K: assert property (trim.low_freq_osc_trim_reg == ROW[23:16])
    else $error("trim 32k");
  AST_TRIM_32M: assert property (trim.fll_32m_trim_reg_b == ROW[31:24])
    else $error("trim 32m");
endmodule
bind lsr_top lsr_top_props #(.ROW(ROW)) u_lsr_top_props (.pclk, .presetn, .ce, .prog_valid, .prog_req,
  .prog_done, .prog_denied, .prog_rdata, .prog_grant, .test_access_en, .debug_access_en, .trim);
`default_nettype wire

/* File: tb/lsr_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lsr_prog_model
  import lsr_pkg::*;
(
  input  wire logic     pclk,
  output logic          prog_valid,
  output lsr_prog_req_t prog_req
);
  initial
  begin
    prog_valid = 1'b0;
    prog_req = '0;
  end
  // Idle lines flip so stale data never looks valid
  task automatic send(input logic [2:0] c, input logic [7:0] d, input int idle);
    repeat (idle) @(posedge pclk);
    @(posedge pclk);
    prog_valid <= 1'b1;
    prog_req <= '{cmd: c, data: d};
    @(posedge pclk);
    prog_valid <= 1'b0;
    prog_req <= ~prog_req;
  endtask
endmodule
`default_nettype wire

/* File: tb/lsr_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module lsr_top_tb_top
  import lsr_pkg::*;
;
  function automatic logic [8*SIG_BYTES-1:0] mk_row();
    logic [8*SIG_BYTES-1:0] r;
    for (int n = 0; n < SIG_BYTES; n++) r[8*n+:8] = 8'hA0 + 8'(n);
    return r;
  endfunction
  localparam logic [8*SIG_BYTES-1:0] ROW = mk_row();
  logic          pclk, presetn, nv_rst_n, ce, psel, penable, pwrite;
  logic          pready, pslverr, prog_valid, prog_done, prog_denied;
  logic          test_access_en, debug_access_en, trim_loaded, er;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [7:0]    prog_rdata;
  lsr_prog_req_t prog_req;
  lsr_grant_t    prog_grant;
  lsr_trim_t     trim;
  int            n_errors, comparisons, cyc;
  // Rows: cmd, data, denied, read byte
  logic [23:0]   rows[22] = '{24'h200000, 24'h000000, 24'h100000, 24'h300000, 24'h500003, 24'h700100,
    24'h402000, 24'h000100, 24'h100000, 24'h200100, 24'h300000, 24'h403000, 24'h500002, 24'h400000,
    24'h000100, 24'h100100, 24'h200100, 24'h300100, 24'h400100, 24'h500100, 24'h600000, 24'h500003};
  logic [4:0]    sig_idx[14] = '{5'h00, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
    5'h10, 5'h12, 5'h13, 5'h14, 5'h15};
  lsr_top #(.ROW(ROW)) u_lsr_top (.pclk, .presetn, .nv_rst_n, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .prog_valid, .prog_req, .prog_done, .prog_denied, .prog_rdata,
    .prog_grant, .test_access_en, .debug_access_en, .trim, .trim_loaded);
  lsr_prog_model u_lsr_prog_model (.pclk, .prog_valid, .prog_req);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [4:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {5'h00, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic prog(input logic [2:0] c, input logic [7:0] d, input int idle);
    u_lsr_prog_model.send(c, d, idle);
    @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Bound well above the roughly 160 cycles the run needs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    {presetn, nv_rst_n, ce, psel, penable, pwrite} = 6'h08;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    chk(32'(trim), {8'h00, ROW[7:0], ROW[23:16], ROW[31:24]});
    chk(32'(trim_loaded), 32'h1);
    presetn <= 1'b1;
    nv_rst_n <= 1'b1;
    foreach (rows[k])
    begin
      prog(rows[k][22:20], rows[k][19:12], k % 3);
      chk(32'(prog_done), 32'h1);
      chk(32'(prog_denied), 32'(rows[k][8]));
      chk(32'(prog_rdata), 32'(rows[k][7:0]));
    end
    foreach (sig_idx[k])
    begin
      apb(1'b0, sig_idx[k], 32'h0);
      chk(rd, 32'(ROW[8*sig_idx[k]+:8]));
    end
    apb(1'b1, 5'h08, 32'hFF);
    chk(32'(er), 32'h1);
    apb(1'b0, 5'h08, 32'h0);
    chk(rd, 32'(ROW[71:64]));
    apb(1'b0, 5'h01, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 5'h18, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h0F);
    prog(CMD_PROT_WRITE, 8'h02, 0);
    chk({test_access_en, debug_access_en}, 32'h0);
    // Level must survive a system reset
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h02);
    chk(32'(trim_loaded), 32'h0);
    // Frozen clock enable must swallow an erase
    ce <= 1'b0;
    prog(CMD_CHIP_ERASE, 8'h00, 0);
    chk(32'(prog_done), 32'h0);
    chk(32'(test_access_en), 32'h0);
    @(posedge pclk);
    ce <= 1'b1;
    prog(CMD_CHIP_ERASE, 8'h00, 0);
    chk(32'(test_access_en), 32'h1);
    apb(1'b1, 5'h19, 32'h1);
    chk(32'(er), 32'h0);
    @(posedge pclk);
    @(negedge pclk);
    chk(32'(trim_loaded), 32'h1);
    chk(32'(trim), {8'h00, ROW[7:0], ROW[23:16], ROW[31:24]});
    finish_test();
  end
endmodule
`default_nettype wire
